// File: src/drfr_map.vh
// Constants of the drive fault auto restart sequencer.
// Contract
// - Restart only after faults of the restartable set.
// - Every restart begins with a forced speed search.
// - Baseblock for the wait time, then check faults.
// - Maximum restart count accepts 0 to 10.
// - At maximum count, stop and latch fault.
// - Ten fault-free minutes after restart clear counter.
// - Manual reset or power cycle clears counter.
// - Count rotating attempts, not skipped ones.
// - Fault output during restart follows its selection.
// - Mode 0 waits time limit, faults when expired.
// - Mode 1 spaces attempts by interval time; code waits it only while a fault remains at the check.
// - Mode 0 counts only successful restarts.
// - Mode 1 counts every attempt, stops past maximum.
// - Undervoltage restarts only with ride-through set 1.
// - Output function code 1e signals restart enabled.
`ifndef DRFR_MAP_VH
`define DRFR_MAP_VH

// Register byte offsets on the Wishbone bus.
`define DRFR_ADR_CFG      8'h00
`define DRFR_ADR_BBWAIT   8'h04
`define DRFR_ADR_TLIMIT   8'h08
`define DRFR_ADR_IVAL     8'h0c
`define DRFR_ADR_DOUT     8'h10
`define DRFR_ADR_CMD      8'h14
`define DRFR_ADR_STATUS   8'h18

// Configuration field positions.
`define DRFR_CFG_MAX_LSB  0
`define DRFR_CFG_FOUT     4
`define DRFR_CFG_MODE     5
`define DRFR_CFG_RT_LSB   6
`define DRFR_CFG_SSEL     8
`define DRFR_CMD_RESET    0

// Limits and reset values; times are in tenths of a second.
`define DRFR_MAX_LIMIT    4'ha
`define DRFR_MAX_RST      4'h0
`define DRFR_BBWAIT_RST   16'h0005
`define DRFR_TLIMIT_RST   16'h0064
`define DRFR_TLIMIT_MIN   16'h0005
`define DRFR_TLIMIT_MAX   16'h0708
`define DRFR_IVAL_RST     16'h0064
`define DRFR_IVAL_MIN     16'h0005
`define DRFR_IVAL_MAX     16'h1770
`define DRFR_RT_ON        2'h1
`define DRFR_FUNC_RESTART 8'h1e
`define DRFR_FUNC_FAULT   8'h0e

// Timing base: clock rate, tick length and counter clear time.
`define DRFR_CLK_HZ       20000000
`define DRFR_TICK_MS      100
`define DRFR_TICK_CYC     ((`DRFR_CLK_HZ / 1000) * `DRFR_TICK_MS)
`define DRFR_CLEAR_S      600
`define DRFR_CLEAR_TICKS  (`DRFR_CLEAR_S * 1000 / `DRFR_TICK_MS)

// Fault vector bit positions.
`define DRFR_F_GROUND     0
`define DRFR_F_OPENPH     1
`define DRFR_F_OVERCUR    2
`define DRFR_F_OVERHEAT   3
`define DRFR_F_MOTOR_OL   4
`define DRFR_F_DRIVE_OL   5
`define DRFR_F_OTORQ1     6
`define DRFR_F_OTORQ2     7
`define DRFR_F_OVERVOLT   8
`define DRFR_F_PHLOSS     9
`define DRFR_F_BRK_RES    10
`define DRFR_F_BRK_TRN    11
`define DRFR_F_UNDERVOLT  12
`define DRFR_F_PULLOUT    13
`define DRFR_NFAULT       14

`endif

// File: src/drfr_timer.v
// Loadable down counter used for ticks and sequence timing.
`default_nettype none
module drfr_timer #(
   parameter W = 16                   // Counter width.
) (
   input  wire         clk_i,         // System clock.
   input  wire         rst_i,         // Synchronous reset.
   input  wire         load_i,        // Load the start value.
   input  wire [W-1:0] val_i,         // Start value.
   input  wire         en_i,          // Count one step.
   output wire         done_o         // Counter stands at zero.
);
   reg [W-1:0] cnt_q;                 // Remaining steps.

   // Load wins over counting; the counter rests at zero.
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= {W{1'b0}};
      end else if (load_i) begin
         cnt_q <= val_i;
      end else if (en_i && (cnt_q != {W{1'b0}})) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign done_o = (cnt_q == {W{1'b0}});
endmodule // drfr_timer
`default_nettype wire

// File: src/drfr_top.v
// Drive fault auto restart sequencer with a Wishbone register slave.
`include "drfr_map.vh"
`default_nettype none
module drfr_top #(
   parameter TICK_CYC   = `DRFR_TICK_CYC,    // Clocks per 0.1 s tick.
   parameter CLR_TICKS  = `DRFR_CLEAR_TICKS  // Ticks of fault-free run.
) (
   input  wire        clk_i,                 // System clock, 20 MHz.
   input  wire        rst_i,                 // Synchronous reset.
   input  wire        wb_cyc_i,              // Wishbone cycle.
   input  wire        wb_stb_i,              // Wishbone strobe.
   input  wire        wb_we_i,               // Wishbone write.
   input  wire [7:0]  wb_adr_i,              // Byte address.
   input  wire [3:0]  wb_sel_i,              // Byte enables.
   input  wire [31:0] wb_dat_i,              // Write data.
   output reg  [31:0] wb_dat_o,              // Read data.
   output reg         wb_ack_o,              // Acknowledge.
   input  wire [13:0] fault_i,               // Restartable fault flags.
   input  wire        other_fault_i,         // Any other major fault.
   input  wire        run_cmd_i,             // Forward or reverse command.
   input  wire        search_done_i,         // Speed search succeeded.
   output reg         baseblock_o,           // Output blocked.
   output reg         speed_search_o,        // Forced speed search.
   output reg         fault_relay_o,         // Fault relay contact.
   output reg         locked_o,              // Fault latched.
   output reg  [2:0]  dout_o                 // Digital outputs 1 to 3.
);
   localparam TW = 21;                       // Tick prescaler width.
   localparam [31:0]   TICK_FULL = TICK_CYC - 1;   // Reload at full width.
   localparam [31:0]   CLR_FULL  = CLR_TICKS;      // Clear time, full width.
   // Both counts are cut to their counter widths on purpose.
   localparam [TW-1:0] TICK_RL   = TICK_FULL[TW-1:0];
   localparam [12:0]   CLR_VAL   = CLR_FULL[12:0];

   // Sequencer states.
   localparam [2:0] S_RUN  = 3'h0;           // Normal operation.
   localparam [2:0] S_BB   = 3'h1;           // Baseblock wait.
   localparam [2:0] S_CHK  = 3'h2;           // Fault self check.
   localparam [2:0] S_SRCH = 3'h3;           // Restart by speed search.
   localparam [2:0] S_WAIT = 3'h4;           // Wait between attempts.
   localparam [2:0] S_LOCK = 3'h5;           // Manual reset needed.

   reg  [3:0]  max_q;                        // Maximum restart count.
   reg         fout_q;                       // Fault output selection.
   reg         mode_q;                       // Counting mode.
   reg  [1:0]  rt_q;                         // Ride-through selection.
   reg         ssel_q;                       // Speed search selection.
   reg  [15:0] bbwait_q;                     // Baseblock wait time.
   reg  [15:0] tlimit_q;                     // Restart time limit.
   reg  [15:0] ival_q;                       // Restart interval time.
   reg  [23:0] dsel_q;                       // Output function codes.
   reg  [3:0]  cnt_q;                        // Restart counter.
   reg  [3:0]  cnt_d;                        // Next restart counter.
   reg  [2:0]  state_q;                      // Sequencer state.
   reg  [2:0]  state_d;                      // Next sequencer state.
   reg  [13:0] flt_q;                        // Fault that began it.
   reg         expired_q;                    // Mode 0 time limit passed.
   reg         expired_d;                    // Next expiry flag.
   reg         armed_q;                      // Clear timer running.
   reg  [15:0] tmr_val;                      // State timer start value.
   reg  [31:0] rd_d;                         // Read mux result.
   reg         ren;                          // Restart enabled level.
   reg  [2:0]  dout_d;                       // Next digital outputs.
   integer     k;                            // Output loop index.

   wire        acc = wb_cyc_i & wb_stb_i & ~wb_ack_o; // Bus access.
   wire        wr  = acc & wb_we_i;          // Write access.
   wire        man_rst;                      // Reset key pushed.
   wire        tick;                         // One 0.1 s tick.
   wire        tmr_done;                     // State timer expired.
   wire        clr_done;                     // Clear timer expired.
   wire        tmr_load = (state_d != state_q); // Restart state timer.
   wire        success;                      // Restart succeeded.
   wire [13:0] rmask;                        // Restartable set mask.
   wire [13:0] rflt;                         // Restartable faults now.
   wire        any_flt;                      // Any fault present.

   // Undervoltage only counts as restartable with ride-through set 1.
   assign rmask = {14{1'b1}} &
                  ~((rt_q != `DRFR_RT_ON) ?
                    (14'h0001 << `DRFR_F_UNDERVOLT) : 14'h0000);
   assign rflt    = fault_i & rmask;
   assign any_flt = (|fault_i) | other_fault_i;
   assign man_rst = wr && (wb_adr_i == `DRFR_ADR_CMD) && wb_sel_i[0] &&
                    wb_dat_i[`DRFR_CMD_RESET];
   assign success = (state_q == S_SRCH) && search_done_i && !any_flt;

   // Free running prescaler that reloads itself at zero.
   drfr_timer #(.W(TW)) u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (tick),
      .val_i  (TICK_RL),
      .en_i   (1'b1),
      .done_o (tick)
   );

   // Per-state timer, loaded on every state change.
   drfr_timer #(.W(16)) u_state (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (tmr_load),
      .val_i  (tmr_val),
      .en_i   (tick),
      .done_o (tmr_done)
   );

   // Fault-free run timer started by each successful restart.
   drfr_timer #(.W(13)) u_clear (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (success),
      .val_i  (CLR_VAL),
      .en_i   (tick),
      .done_o (clr_done)
   );

   // Timer start value for the state being entered.
   always @* begin
      tmr_val = 16'h0000;
      if (state_d == S_BB) begin
         tmr_val = bbwait_q;
      end else if (state_d == S_WAIT) begin
         tmr_val = mode_q ? ival_q : tlimit_q;
      end
   end

   // Next state and counter. A new fault ends the search at once.
   always @* begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      expired_d = expired_q;
      case (state_q)
         S_RUN: begin
            expired_d = 1'b0;
            if (other_fault_i || (|(fault_i & ~rmask))) begin
               state_d = S_LOCK;
            end else if (|rflt) begin
               if ((max_q == 4'h0) || (cnt_q >= max_q)) begin
                  state_d = S_LOCK;
               end else begin
                  state_d = S_BB;
               end
            end
         end
         S_BB: begin
            if (tmr_done) begin
               state_d = S_CHK;
            end
         end
         S_CHK: begin
            // The self check waits until the run command is gone.
            if (!run_cmd_i) begin
               if (any_flt) begin
                  // No rotation was tried, so nothing is counted.
                  if (!mode_q && expired_q) begin
                     state_d = S_LOCK;
                  end else begin
                     state_d = S_WAIT;
                  end
               end else if (mode_q && (cnt_q >= max_q)) begin
                  state_d = S_LOCK;
               end else begin
                  state_d = S_SRCH;
                  if (mode_q) begin
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
         end
         S_SRCH: begin
            if (any_flt) begin
               state_d = S_BB;
            end else if (search_done_i) begin
               state_d = S_RUN;
               if (!mode_q) begin
                  cnt_d = cnt_q + 4'h1;
               end
            end
         end
         S_WAIT: begin
            if (tmr_done) begin
               state_d   = S_CHK;
               expired_d = ~mode_q;
            end
         end
         S_LOCK: begin
            if (man_rst) begin
               state_d = S_RUN;
            end
         end
         default: begin
            state_d = S_LOCK;
         end
      endcase
      // Counter clearing overrides counting.
      if (man_rst || (armed_q && clr_done)) begin
         cnt_d = 4'h0;
      end
   end

   // Sequencer registers; reset stands for a control power cycle.
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q   <= S_RUN;
         cnt_q     <= 4'h0;
         expired_q <= 1'b0;
         flt_q     <= 14'h0000;
         armed_q   <= 1'b0;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         expired_q <= expired_d;
         if ((state_q == S_RUN) && (state_d != S_RUN)) begin
            flt_q <= fault_i;
         end
         // A new fault stops the fault-free run clock.
         if (success) begin
            armed_q <= 1'b1;
         end else if (any_flt || clr_done) begin
            armed_q <= 1'b0;
         end
      end
   end

   // Output levels decoded from the next state so they leave a flop.
   always @* begin
      ren = (state_d == S_BB) || (state_d == S_CHK) ||
            (state_d == S_SRCH) || (state_d == S_WAIT);
      dout_d = 3'h0;
      for (k = 0; k < 3; k = k + 1) begin
         if (dsel_q[k*8 +: 8] == `DRFR_FUNC_RESTART) begin
            dout_d[k] = ren;
         end else if (dsel_q[k*8 +: 8] == `DRFR_FUNC_FAULT) begin
            dout_d[k] = (state_d == S_LOCK) || (ren && fout_q);
         end
      end
   end

   // Drive outputs, all registered.
   always @(posedge clk_i) begin
      if (rst_i) begin
         baseblock_o    <= 1'b0;
         speed_search_o <= 1'b0;
         fault_relay_o  <= 1'b0;
         locked_o       <= 1'b0;
         dout_o         <= 3'h0;
      end else begin
         baseblock_o    <= (state_d != S_RUN) && (state_d != S_SRCH);
         // Search is forced whatever the selection bit holds.
         speed_search_o <= (state_d == S_SRCH);
         fault_relay_o  <= (state_d == S_LOCK) || (ren && fout_q);
         locked_o       <= (state_d == S_LOCK);
         dout_o         <= dout_d;
      end
   end

   // Register writes; out-of-range settings are clamped.
   always @(posedge clk_i) begin
      if (rst_i) begin
         max_q    <= `DRFR_MAX_RST;
         fout_q   <= 1'b0;
         mode_q   <= 1'b0;
         rt_q     <= 2'h0;
         ssel_q   <= 1'b0;
         bbwait_q <= `DRFR_BBWAIT_RST;
         tlimit_q <= `DRFR_TLIMIT_RST;
         ival_q   <= `DRFR_IVAL_RST;
         dsel_q   <= 24'h000000;
      end else if (wr) begin
         if (wb_adr_i == `DRFR_ADR_CFG) begin
            if (wb_sel_i[0]) begin
               if (wb_dat_i[3:0] > `DRFR_MAX_LIMIT) begin
                  max_q <= `DRFR_MAX_LIMIT;
               end else begin
                  max_q <= wb_dat_i[3:0];
               end
               fout_q <= wb_dat_i[`DRFR_CFG_FOUT];
               mode_q <= wb_dat_i[`DRFR_CFG_MODE];
               rt_q   <= wb_dat_i[`DRFR_CFG_RT_LSB +: 2];
            end
            if (wb_sel_i[1]) begin
               ssel_q <= wb_dat_i[`DRFR_CFG_SSEL];
            end
         end else if (wb_adr_i == `DRFR_ADR_BBWAIT) begin
            if (wb_sel_i[1:0] == 2'h3) begin
               bbwait_q <= wb_dat_i[15:0];
            end
         end else if (wb_adr_i == `DRFR_ADR_TLIMIT) begin
            if (wb_sel_i[1:0] == 2'h3) begin
               if (wb_dat_i[15:0] < `DRFR_TLIMIT_MIN) begin
                  tlimit_q <= `DRFR_TLIMIT_MIN;
               end else if (wb_dat_i[15:0] > `DRFR_TLIMIT_MAX) begin
                  tlimit_q <= `DRFR_TLIMIT_MAX;
               end else begin
                  tlimit_q <= wb_dat_i[15:0];
               end
            end
         end else if (wb_adr_i == `DRFR_ADR_IVAL) begin
            if (wb_sel_i[1:0] == 2'h3) begin
               if (wb_dat_i[15:0] < `DRFR_IVAL_MIN) begin
                  ival_q <= `DRFR_IVAL_MIN;
               end else if (wb_dat_i[15:0] > `DRFR_IVAL_MAX) begin
                  ival_q <= `DRFR_IVAL_MAX;
               end else begin
                  ival_q <= wb_dat_i[15:0];
               end
            end
         end else if (wb_adr_i == `DRFR_ADR_DOUT) begin
            if (wb_sel_i[0]) begin
               dsel_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               dsel_q[15:8] <= wb_dat_i[15:8];
            end
            if (wb_sel_i[2]) begin
               dsel_q[23:16] <= wb_dat_i[23:16];
            end
         end
      end
   end

   // Read mux; unmapped addresses answer with zero.
   always @* begin
      rd_d = 32'h00000000;
      if (wb_adr_i == `DRFR_ADR_CFG) begin
         rd_d[8:0] = {ssel_q, rt_q, mode_q, fout_q, max_q};
      end else if (wb_adr_i == `DRFR_ADR_BBWAIT) begin
         rd_d[15:0] = bbwait_q;
      end else if (wb_adr_i == `DRFR_ADR_TLIMIT) begin
         rd_d[15:0] = tlimit_q;
      end else if (wb_adr_i == `DRFR_ADR_IVAL) begin
         rd_d[15:0] = ival_q;
      end else if (wb_adr_i == `DRFR_ADR_DOUT) begin
         rd_d[23:0] = dsel_q;
      end else if (wb_adr_i == `DRFR_ADR_STATUS) begin
         rd_d[29:0] = {flt_q, 7'h00, fault_relay_o, locked_o,
                       state_q, cnt_q};
      end
   end

   // Single-wait Wishbone answer: ack one cycle after the strobe.
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= acc;
         if (acc && !wb_we_i) begin
            wb_dat_o <= rd_d;
         end
      end
   end
endmodule // drfr_top
`default_nettype wire

// File: sim/drfr_monitor.sv
// Port checker for the fault restart sequencer.
`default_nettype none
module drfr_monitor #(
   parameter TICK_CYC  = 4,    // Clocks per tick.
   parameter CLR_TICKS = 20    // Fault-free ticks that clear the count.
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic        wb_ack_o,
   input wire logic [13:0] fault_i,
   input wire logic        other_fault_i,
   input wire logic        run_cmd_i,
   input wire logic        search_done_i,
   input wire logic        baseblock_o,
   input wire logic        speed_search_o,
   input wire logic        fault_relay_o,
   input wire logic        locked_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A bus request that has not been answered yet.
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // No fault of any kind is present.
   sequence s_quiet;
      fault_i == 14'h0 && !other_fault_i;
   endsequence
   a_ack_follows_req: assert property (s_req |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_bb_min_hold: assert property ($rose(baseblock_o) && !locked_o
      |-> baseblock_o[*8])
      else $error("baseblock too short");
   a_bb_no_search: assert property (!(baseblock_o && speed_search_o))
      else $error("search while blocked");
   a_search_when_clear: assert property ($rose(speed_search_o) |->
      $past(fault_i) == 14'h0 && !$past(run_cmd_i))
      else $error("search started with fault or run command");
   a_search_ends_run: assert property (speed_search_o && search_done_i
      ##0 s_quiet |=> !speed_search_o && !baseblock_o)
      else $error("search success did not resume run");
   a_fault_in_search: assert property (speed_search_o && fault_i != 14'h0
      |=> !speed_search_o && (baseblock_o || locked_o))
      else $error("fault during search not blocked");
   a_lock_holds: assert property (locked_o && !(wb_cyc_i && wb_we_i)
      |=> locked_o)
      else $error("lock dropped without manual reset");
   a_lock_relay: assert property (locked_o |-> fault_relay_o)
      else $error("relay open while locked");
endmodule // drfr_monitor
`default_nettype wire

// File: sim/drfr_motor_model.sv
// Partner model: outside run sequence and the motor being caught.
`default_nettype none
module drfr_motor_model (
   input  wire logic clk_i,         // System clock.
   input  wire logic rst_i,         // Synchronous reset.
   input  wire logic baseblock_i,   // Drive output blocked.
   input  wire logic search_i,      // Speed search under way.
   input  wire logic slow_i,        // Motor is slow to be caught.
   output var  logic run_cmd_o,     // Forward or reverse command.
   output var  logic search_done_o  // Motor caught.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_q;  // Cycles spent searching.
   // The run command drops on a trip so the drive may self-check; it comes
   // back once the motor is caught, as a real sequence would do.
   always @(posedge clk_i) begin
      if (rst_i) begin
         run_cmd_o <= 1'h1;
         search_done_o <= 1'h0;
         cnt_q <= 8'h0;
      end else if (baseblock_i) begin
         run_cmd_o <= 1'h0;
         cnt_q <= 8'h0;
      end else if (search_i) begin
         cnt_q <= cnt_q + 8'h1;
         if (cnt_q == (slow_i ? 8'hff : 8'h3)) begin
            search_done_o <= 1'h1;
            run_cmd_o <= 1'h1;
         end
      end else begin
         search_done_o <= 1'h0;
         cnt_q <= 8'h0;
      end
   end
endmodule // drfr_motor_model
`default_nettype wire

// File: sim/drfr_top_test.sv
// Self-checking bench for the fault restart sequencer.
`default_nettype none
module drfr_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam TICK = 4;   // Short tick keeps the run brief.
   localparam CLR = 20;   // Fault-free ticks that clear the count.
   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        cyc = 1'h0, stb = 1'h0, we = 1'h0;
   logic [7:0]  adr = 8'h0;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [13:0] flt = 14'h0;   // Restartable faults.
   logic        oflt = 1'h0;   // Non-restartable fault.
   logic        slow = 1'h0;   // Partner catches the motor slowly.
   logic [31:0] rdat, s;       // Read data and last bus result.
   logic        ack, bb, ss, relay, lock, run, done;
   logic [2:0]  dout;
   int          error_cnt = 0, total_checks = 0;
   always #25 clk_i = ~clk_i;
   drfr_top #(.TICK_CYC(TICK), .CLR_TICKS(CLR)) i_drfr_top (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .fault_i(flt), .other_fault_i(oflt), .run_cmd_i(run),
      .search_done_i(done), .baseblock_o(bb), .speed_search_o(ss),
      .fault_relay_o(relay), .locked_o(lock), .dout_o(dout));
   drfr_motor_model i_drfr_motor_model (.clk_i(clk_i), .rst_i(rst_i),
      .baseblock_i(bb), .search_i(ss), .slow_i(slow), .run_cmd_o(run),
      .search_done_o(done));
   // Counts one comparison and reports a mismatch at once.
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic bus cycle; the request holds until ack is seen high.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, 4'hf};
      do @(posedge clk_i); while (ack !== 1'h1 && ++n < 20);
      if (n >= 20) error_cnt++;
      s = rdat;
      {cyc, stb, we} <= 3'h0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask
   task rd(input logic [7:0] a);
      bus(1'h0, a, 32'h0);
   endtask
   // Polls the status word until the sequencer shows the wanted state.
   task wst(input logic [2:0] st);
      int n;
      n = 0;
      do rd(8'h18); while (s[6:4] !== st && ++n < 300);
      chk("state", {29'h0, st}, {29'h0, s[6:4]});
   endtask
   // A one-cycle fault pulse; the trip is latched by the sequencer.
   task trip(input logic [13:0] f);
      @(posedge clk_i);
      flt <= f;
      @(posedge clk_i);
      flt <= 14'h0;
   endtask
   task t_defaults;
      logic [7:0]  a [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c};
      logic [31:0] e [5] = '{32'h0, 32'h5, 32'h64, 32'h64, 32'h0};
      for (int i = 0; i < 5; i++) begin
         rd(a[i]);
         chk("reset value", e[i], s);
      end
   endtask
   // With no restarts allowed a trip latches until a manual reset.
   task t_max_zero;
      trip(14'h1);
      wst(3'h5);
      chk("lock relay", 32'h3, {30'h0, lock, relay});
      wr(8'h14, 32'h1);
      rd(8'h18);
      chk("cleared", 32'h0, s & 32'hff);
   endtask
   // Every restartable fault restarts once; successes are counted.
   task t_mode0;
      wr(8'h10, 32'h0e1e);
      wr(8'h00, 32'h5a);
      for (int i = 0; i < 14; i++) begin
         if (i == 10) wr(8'h14, 32'h1);
         trip(14'h1 << i);
         wst(3'h1);
         chk("restart outs", 32'hb, {28'h0, relay, dout});
         wst(3'h0);
         chk("count", 32'((i < 10) ? i + 1 : i - 9), {28'h0, s[3:0]});
         chk("run outs", 32'h0, {28'h0, relay, dout});
      end
   endtask
   task t_clear;
      repeat ((CLR + 2) * TICK) @(posedge clk_i);
      rd(8'h18);
      chk("idle clear", 32'h0, {28'h0, s[3:0]});
   endtask
   // Lasting, masked and other faults all end latched.
   task t_faults;
      wr(8'h08, 32'h5);
      flt <= 14'h4;
      wst(3'h5);
      chk("no attempt", 32'h0, {28'h0, s[3:0]});
      flt <= 14'h0;
      wr(8'h14, 32'h1);
      wr(8'h00, 32'h1a);
      trip(14'h1000);
      wst(3'h5);
      wr(8'h14, 32'h1);
      oflt <= 1'h1;
      wst(3'h5);
      oflt <= 1'h0;
      wr(8'h14, 32'h1);
   endtask
   // Attempts count even when the search fails; the limit then latches.
   task t_mode1;
      wr(8'h0c, 32'h5);
      wr(8'h00, 32'h22);
      slow <= 1'h1;
      trip(14'h1);
      for (int k = 1; k <= 2; k++) begin
         wst(3'h1);
         chk("relay off", 32'h0, {31'h0, relay});
         chk("blocked", 32'h2, {30'h0, bb, ss});
         wst(3'h3);
         chk("search outs", 32'h1, {30'h0, bb, ss});
         chk("attempts", 32'(k), {28'h0, s[3:0]});
         trip(14'h4);
      end
      wst(3'h5);
      chk("final", 32'h2, {28'h0, s[3:0]});
      // A lasting fault waits out the interval and counts nothing.
      wr(8'h14, 32'h1);
      flt <= 14'h1;
      wst(3'h4);
      chk("no attempt", 32'h0, {28'h0, s[3:0]});
      flt <= 14'h0;
      wst(3'h3);
      chk("first try", 32'h1, {28'h0, s[3:0]});
      slow <= 1'h0;
   endtask
   task tally_and_finish;
      if (error_cnt == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      t_defaults();
      t_max_zero();
      t_mode0();
      t_clear();
      t_faults();
      t_mode1();
      tally_and_finish();
   end
   // Cuts a hang short; the tests need well under this span.
   initial begin
      #2000000;
      error_cnt++;
      tally_and_finish();
   end
endmodule // drfr_top_test
bind drfr_top drfr_monitor #(.TICK_CYC(TICK_CYC), .CLR_TICKS(CLR_TICKS))
   i_drfr_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
   .fault_i(fault_i), .other_fault_i(other_fault_i), .run_cmd_i(run_cmd_i),
   .search_done_i(search_done_i), .baseblock_o(baseblock_o),
   .speed_search_o(speed_search_o), .fault_relay_o(fault_relay_o),
   .locked_o(locked_o));
`default_nettype wire
